// ---- verif/csb_unit_properties.sv ----
// checker for the compare, skip and branch unit
// assumes it is bound to csb_unit and sees only its ports
`timescale 1ns/100ps
module csb_unit_properties
  import csb_pkg::*;
#(parameter int unsigned PC_W = 16) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire logic issue_valid,
  input wire csb_pkg::csb_issue_t issue,
  input wire logic [PC_W-1:0] issue_pc,
  input wire logic issue_ready,
  // core state and results
  input wire logic [7:0] flags_in,
  input wire logic [PC_W-1:0] stack_data,
  input wire logic stack_pop_req,
  input wire logic done,
  input wire logic flags_we,
  input wire logic [7:0] flags_out,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic flush
);
  import csb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decode at the take edge; a condition map indexed by opcode is short
  wire logic take = issue_valid && issue_ready;
  wire logic is_ret = issue.op == CSB_INTERRUPT_RETURN_OP;
  wire logic is_cmp = issue.op inside {[4'h3:4'h5]};
  wire logic is_skip = issue.op inside {4'h2, [4'h6:4'h9]};
  wire logic is_br = issue.op >= CSB_BRANCH_FLAG_SET_OP;
  wire logic zf = flags_in[CSB_FLAG_Z];
  wire logic cf = flags_in[CSB_FLAG_C];
  wire logic rb = issue.rr_val[issue.bit_sel];
  wire logic [15:0] hit_map = {1'h0, !cf, cf, !zf, zf,
    flags_in[issue.bit_sel], issue.io_bit, !issue.io_bit, rb, !rb, 3'h0,
    issue.rd_val == issue.rr_val, 2'h0};
  wire logic hit = hit_map[issue.op];
  wire logic [PC_W-1:0] tgt = issue_pc + PC_W'(1) +
    {{(PC_W-7){issue.offset[6]}}, issue.offset};
  a_ret_pop_busy: assert property (take && is_ret |=> stack_pop_req &&
    !issue_ready ##1 !issue_ready ##1 !issue_ready)
    else $error("return did not pop or refuse issue");
  // return loads pc and sets I
  a_ret_load_pc: assert property (take && is_ret |-> ##4 done && pc_load &&
    flags_we && flags_out == ($past(flags_in, 4) | 8'h80) &&
    pc_value == $past(stack_data)) else $error("return result wrong");
  a_cmp_one_cycle: assert property (take && is_cmp |=> done && flags_we &&
    !pc_load) else $error("compare not done in one cycle");
  a_skip_miss_one: assert property (take && is_skip && !hit |=> done &&
    !pc_load && !flags_we) else $error("false skip wrong");
  a_skip_one_word: assert property (take && is_skip && hit &&
    !issue.next_two_word |=> !done ##1 done && pc_load && !flags_we &&
    pc_value == $past(issue_pc, 2) + PC_W'(2)) else $error("skip 2 wrong");
  a_skip_two_word: assert property (take && is_skip && hit &&
    issue.next_two_word |=> !done [*2] ##1 done && pc_load && !flags_we &&
    pc_value == $past(issue_pc, 3) + PC_W'(3)) else $error("skip 3 wrong");
  a_br_taken_two: assert property (take && is_br && hit |=> !done ##1
    done && flush && !flags_we && pc_value == $past(tgt, 2))
    else $error("taken branch wrong");
  a_br_miss_one: assert property (take && is_br && !hit |=> done &&
    !pc_load && !flags_we) else $error("untaken branch wrong");
  a_flush_with_load: assert property (flush == pc_load &&
    (!pc_load || done)) else $error("flush and load differ");
  // main scenarios
  c_return: cover property (take && is_ret);
  c_skip_two: cover property (take && is_skip && hit && issue.next_two_word);
  c_br_taken: cover property (take && is_br && hit);
endmodule : csb_unit_properties

bind csb_unit csb_unit_properties #(.PC_W(PC_W)) u_props (.clk(clk),
  .rst_n(rst_n), .issue_valid(issue_valid), .issue(issue),
  .issue_pc(issue_pc), .issue_ready(issue_ready), .flags_in(flags_in),
  .stack_data(stack_data), .stack_pop_req(stack_pop_req), .done(done),
  .flags_we(flags_we), .flags_out(flags_out), .pc_load(pc_load),
  .pc_value(pc_value), .flush(flush));

// ---- verif/test_csb_unit.sv ----
// self-checking bench for the compare, skip and branch unit
// assumes csb_pkg, csb_unit and the bound checker are compiled with it
`timescale 1ns/100ps
module test_csb_unit;
  import csb_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic issue_valid = 1'h0;
  csb_issue_t issue = '0;
  logic [15:0] issue_pc = 16'h0000;
  logic [7:0] flags_in = 8'h00;
  logic [15:0] stack_data = 16'h0000;
  logic issue_ready, stack_pop_req, done, flags_we, pc_load, flush;
  logic [7:0] flags_out;
  logic [15:0] pc_value;
  int mismatches = 0;
  int comparisons = 0;
  csb_issue_t r;
  csb_unit #(.PC_W(16)) u_dut (.clk(clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue(issue), .issue_pc(issue_pc),
    .issue_ready(issue_ready), .flags_in(flags_in), .stack_data(stack_data),
    .stack_pop_req(stack_pop_req), .done(done), .flags_we(flags_we),
    .flags_out(flags_out), .pc_load(pc_load), .pc_value(pc_value),
    .flush(flush));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // expected cycles, flags and pc worked out from the operands
  function automatic void predict(input csb_issue_t i, input logic [15:0] pc,
      input logic [7:0] f, input logic [15:0] sd, output int n,
      output logic we, output logic [7:0] fo, output logic ld,
      output logic [15:0] pv);
    logic [7:0] b;
    logic cin;
    logic [8:0] d;
    logic [4:0] h;
    logic [15:0] m;
    b = (i.op == CSB_COMPARE_IMMEDIATE_OP) ? i.imm : i.rr_val;
    cin = (i.op == CSB_COMPARE_WITH_CARRY_OP) && f[CSB_FLAG_C];
    d = {1'h0, i.rd_val} - {1'h0, b} - 9'(cin);
    h = {1'h0, i.rd_val[3:0]} - {1'h0, b[3:0]} - 5'(cin);
    fo = f;
    fo[CSB_FLAG_C] = d[8];
    fo[CSB_FLAG_Z] = d[7:0] == 8'h00;
    fo[CSB_FLAG_N] = d[7];
    fo[CSB_FLAG_V] = (i.rd_val[7] ^ b[7]) & (i.rd_val[7] ^ d[7]);
    fo[CSB_FLAG_H] = h[4];
    m = {!f[CSB_FLAG_C], f[CSB_FLAG_C], !f[CSB_FLAG_Z], f[CSB_FLAG_Z],
      f[i.bit_sel], i.io_bit, !i.io_bit, i.rr_val[i.bit_sel],
      !i.rr_val[i.bit_sel], 3'h0, i.rd_val == i.rr_val, 2'h0} >> 0;
    ld = m[i.op] || i.op == CSB_INTERRUPT_RETURN_OP;
    we = i.op inside {[4'h3:4'h5], CSB_INTERRUPT_RETURN_OP};
    n = ld ? 2 : 1;
    pv = pc + {{9{i.offset[6]}}, i.offset} + 16'h0001;
    if (i.op == CSB_INTERRUPT_RETURN_OP) begin
      n = 4;
      fo = f | 8'h80;
      pv = sd;
    end else if (i.op < CSB_BRANCH_FLAG_SET_OP) begin
      n = ld ? (i.next_two_word ? 3 : 2) : 1;
      pv = pc + 16'(n);
    end
  endfunction : predict
  // offer one instruction, left offered while refused, then check
  task automatic run(input csb_issue_t i, input logic [7:0] f);
    int n;
    int k;
    logic we;
    logic ld;
    logic [7:0] fo;
    logic [15:0] pv;
    issue_pc = 16'($urandom);
    stack_data = 16'($urandom);
    predict(i, issue_pc, f, stack_data, n, we, fo, ld, pv);
    issue = i;
    flags_in = f;
    issue_valid = 1'h1;
    @(posedge clk);
    #1;
    k = 1;
    while (done !== 1'h1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(16'(k), 16'(n), "cycles");
    if (k == 8) report_and_stop();
    chk(16'(flags_we), 16'(we), "flags_we");
    if (we) chk(16'(flags_out), 16'(fo), "flags");
    chk(16'(pc_load), 16'(ld), "pc_load");
    if (ld) chk(pc_value, pv, "pc");
    chk(16'(flush), 16'(ld), "flush");
  endtask : run
  initial begin
    void'($urandom(91218));
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    // borrow through carry, overflow, half borrow, far branch, two-word skip
    run('{CSB_COMPARE_WITH_CARRY_OP, 8'h00, 8'h00, 8'h00, 3'h0, 1'h0,
      7'h00, 1'h0}, 8'h03);
    run('{CSB_COMPARE_REGS_OP, 8'h80, 8'h01, 8'h00, 3'h0, 1'h0, 7'h00,
      1'h0}, 8'h00);
    run('{CSB_COMPARE_IMMEDIATE_OP, 8'h10, 8'h00, 8'h01, 3'h0, 1'h0,
      7'h00, 1'h0}, 8'h00);
    run('{CSB_BRANCH_FLAG_SET_OP, 8'h00, 8'h00, 8'h00, 3'h7, 1'h0, 7'h40,
      1'h0}, 8'h80);
    run('{CSB_COMPARE_SKIP_EQUAL_OP, 8'h5A, 8'h5A, 8'h00, 3'h0, 1'h0,
      7'h00, 1'h1}, 8'h00);
    for (int t = 0; t < 600; t++) begin
      r = '0;
      {r.rd_val, r.rr_val, r.imm, r.bit_sel, r.io_bit, r.offset,
        r.next_two_word} = 36'({$urandom, $urandom});
      r.op = csb_op_t'($urandom_range(0, 14));
      if ($urandom_range(0, 3) == 0) r.rr_val = r.rd_val;
      run(r, 8'($urandom));
    end
    issue.op = CSB_INTERRUPT_RETURN_OP;
    repeat (2) @(posedge clk);
    // reset in mid-return clears the pulses and readies the unit
    #1 rst_n = 1'h0;
    issue_valid = 1'h0;
    #1 chk(16'({done, pc_load, stack_pop_req, issue_ready}), 16'h0001, "rst");
    @(posedge clk);
    #1 rst_n = 1'h1;
    run('{CSB_BRANCH_NOT_EQUAL_OP, 8'h00, 8'h00, 8'h00, 3'h0, 1'h0, 7'h3F,
      1'h0}, 8'h00);
    report_and_stop();
  end
endmodule : test_csb_unit

// ---- verilog/csb_pkg.sv ----
// package for the compare, skip and branch execution unit
// assumes the core decodes opcodes into csb_op_t before issue
package csb_pkg;

  // ----------------------------------------------------------------
  // operation codes handed over by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSB_NOP = 4'h0,
    CSB_INTERRUPT_RETURN_OP = 4'h1,
    CSB_COMPARE_SKIP_EQUAL_OP = 4'h2,
    CSB_COMPARE_REGS_OP = 4'h3,
    CSB_COMPARE_WITH_CARRY_OP = 4'h4,
    CSB_COMPARE_IMMEDIATE_OP = 4'h5,
    CSB_SKIP_REG_BIT_CLEAR_OP = 4'h6,
    CSB_SKIP_REG_BIT_SET_OP = 4'h7,
    CSB_SKIP_IO_BIT_CLEAR_OP = 4'h8,
    CSB_SKIP_IO_BIT_SET_OP = 4'h9,
    CSB_BRANCH_FLAG_SET_OP = 4'hA,
    CSB_BRANCH_EQUAL_OP = 4'hB,
    CSB_BRANCH_NOT_EQUAL_OP = 4'hC,
    CSB_BRANCH_CARRY_SET_OP = 4'hD,
    CSB_BRANCH_CARRY_CLEAR_OP = 4'hE
  } csb_op_t;

  // ----------------------------------------------------------------
  // status_flags_register bit positions
  // ----------------------------------------------------------------
  localparam int unsigned CSB_FLAG_C = 0;
  localparam int unsigned CSB_FLAG_Z = 1;
  localparam int unsigned CSB_FLAG_N = 2;
  localparam int unsigned CSB_FLAG_V = 3;
  localparam int unsigned CSB_FLAG_H = 5;
  localparam int unsigned CSB_FLAG_I = 7;

  // ----------------------------------------------------------------
  // cycle counts and program counter steps
  // ----------------------------------------------------------------
  localparam logic [2:0] CSB_CYC_RETURN = 3'h4;
  localparam logic [2:0] CSB_CYC_ONE = 3'h1;
  localparam logic [2:0] CSB_CYC_TWO = 3'h2;
  localparam logic [2:0] CSB_CYC_THREE = 3'h3;
  localparam int unsigned CSB_SKIP_ONE_WORD = 2;
  localparam int unsigned CSB_SKIP_TWO_WORD = 3;
  localparam int unsigned CSB_OFFSET_W = 7;

  // issued instruction with its operands
  typedef struct packed {
    csb_op_t op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic io_bit;
    logic [6:0] offset;
    logic next_two_word;
  } csb_issue_t;

endpackage : csb_pkg

// ---- verilog/csb_unit.sv ----
// execution unit for compare, conditional skip, relative branch and
// interrupt return instructions of an 8-bit core
// assumes: the decoder presents one instruction per issue handshake,
// the stack unit pops the return address on stack_pop_req and holds it
// on stack_data until the unit finishes; flags_in is the live register
//
// What this block does
// - interrupt return loads the pc from the stack, sets I, 4 cycles
// - compare-skip-equal skips when both registers match, no flags
// - register compare sets Z N V C H from rd minus rr in one cycle
// - compare with carry sets Z N V C H from rd minus rr minus C
// - compare immediate sets Z N V C H from rd minus the constant
// - skip-reg-bit-clear skips when the chosen register bit is 0
// - skip-reg-bit-set skips when the chosen register bit is 1
// - skip-io-bit-clear skips when the chosen I/O bit reads 0
// - skip-io-bit-set skips when the chosen I/O bit reads 1
// - branch-flag-set jumps by offset plus one when the flag is 1
// - branch-equal jumps by offset plus one when Z is 1
// - branch-not-equal jumps by offset plus one when Z is 0
// - branch-carry-set jumps by offset plus one when C is 1
// - branch-carry-clear jumps by offset plus one when C is 0
`timescale 1ns/100ps

module csb_unit #(
  parameter int unsigned PC_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue
  input wire logic issue_valid,
  input wire csb_pkg::csb_issue_t issue,
  input wire logic [PC_W-1:0] issue_pc,
  output logic issue_ready,
  // core state
  input wire logic [7:0] flags_in,
  input wire logic [PC_W-1:0] stack_data,
  output logic stack_pop_req,
  // results
  output logic done,
  output logic flags_we,
  output logic [7:0] flags_out,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic flush
);
  import csb_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (PC_W < CSB_OFFSET_W + 1) begin : g_bad_pc_w
    $error("PC_W too narrow for the branch offset");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSB_IDLE = 2'b01,
    CSB_HOLD = 2'b10
  } csb_state_t;

  csb_state_t state;
  csb_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic pend_ret;
  logic pend_flags_we;
  logic [7:0] pend_flags;
  logic pend_pc_load;
  logic [PC_W-1:0] pend_pc;

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  wire logic take = issue_valid & issue_ready;
  wire logic is_ret = issue.op == CSB_INTERRUPT_RETURN_OP;
  wire logic is_compare_skip_equal_op = issue.op == CSB_COMPARE_SKIP_EQUAL_OP;
  wire logic is_cp = issue.op == CSB_COMPARE_REGS_OP;
  wire logic is_cpc = issue.op == CSB_COMPARE_WITH_CARRY_OP;
  wire logic is_cpi = issue.op == CSB_COMPARE_IMMEDIATE_OP;
  wire logic is_skip_reg_bit_clear_op = issue.op == CSB_SKIP_REG_BIT_CLEAR_OP;
  wire logic is_skip_reg_bit_set_op = issue.op == CSB_SKIP_REG_BIT_SET_OP;
  wire logic is_skip_io_bit_clear_op = issue.op == CSB_SKIP_IO_BIT_CLEAR_OP;
  wire logic is_skip_io_bit_set_op = issue.op == CSB_SKIP_IO_BIT_SET_OP;
  wire logic is_bflag = issue.op == CSB_BRANCH_FLAG_SET_OP;
  wire logic is_beq = issue.op == CSB_BRANCH_EQUAL_OP;
  wire logic is_bne = issue.op == CSB_BRANCH_NOT_EQUAL_OP;
  wire logic is_bcs = issue.op == CSB_BRANCH_CARRY_SET_OP;
  wire logic is_bcc = issue.op == CSB_BRANCH_CARRY_CLEAR_OP;
  wire logic is_cmp = is_cp | is_cpc | is_cpi;
  wire logic is_skip = is_compare_skip_equal_op | is_skip_reg_bit_clear_op | is_skip_reg_bit_set_op | is_skip_io_bit_clear_op | is_skip_io_bit_set_op;
  wire logic is_branch = is_bflag | is_beq | is_bne | is_bcs | is_bcc;

  // ----------------------------------------------------------------
  // subtractor shared by the three compares; result is never stored
  // ----------------------------------------------------------------
  // immediate operand
  wire logic [7:0] sub_b = is_cpi ? issue.imm : issue.rr_val;
  wire logic cin = is_cpc & flags_in[CSB_FLAG_C];
  wire logic [8:0] diff = {1'b0, issue.rd_val} - {1'b0, sub_b}
                          - {8'h00, cin};
  wire logic [7:0] res = diff[7:0];
  wire logic [7:0] d = issue.rd_val;
  // half and full borrow, overflow in two's complement
  wire logic h_f = (~d[3] & sub_b[3]) | (sub_b[3] & res[3])
                   | (res[3] & ~d[3]);
  wire logic c_f = (~d[7] & sub_b[7]) | (sub_b[7] & res[7])
                   | (res[7] & ~d[7]);
  wire logic v_f = (d[7] & ~sub_b[7] & ~res[7])
                   | (~d[7] & sub_b[7] & res[7]);
  wire logic z_f = res == 8'h00;
  wire logic n_f = res[7];

  // flags Z N V C H updated, others kept
  wire logic [7:0] cmp_flags = {
    flags_in[7:6], h_f, flags_in[4], v_f, n_f, z_f, c_f
  };

  wire logic [7:0] ret_flags = flags_in | (8'h01 << CSB_FLAG_I);

  // ----------------------------------------------------------------
  // skip conditions
  // ----------------------------------------------------------------
  wire logic reg_bit = issue.rr_val[issue.bit_sel];
  wire logic skip_eq = is_compare_skip_equal_op & (issue.rd_val == issue.rr_val);
  wire logic skip_rc = is_skip_reg_bit_clear_op & ~reg_bit;
  wire logic skip_rs = is_skip_reg_bit_set_op & reg_bit;
  wire logic skip_ic = is_skip_io_bit_clear_op & ~issue.io_bit;
  wire logic skip_is = is_skip_io_bit_set_op & issue.io_bit;
  wire logic skip_cond = skip_eq | skip_rc | skip_rs | skip_ic | skip_is;

  // ----------------------------------------------------------------
  // branch conditions
  // ----------------------------------------------------------------
  // selected status bit
  wire logic br_flag = is_bflag & flags_in[issue.bit_sel];
  wire logic br_eq = is_beq & flags_in[CSB_FLAG_Z];
  wire logic br_ne = is_bne & ~flags_in[CSB_FLAG_Z];
  wire logic br_cs = is_bcs & flags_in[CSB_FLAG_C];
  wire logic br_cc = is_bcc & ~flags_in[CSB_FLAG_C];
  wire logic br_cond = br_flag | br_eq | br_ne | br_cs | br_cc;

  // ----------------------------------------------------------------
  // program counter targets
  // ----------------------------------------------------------------
  // sign extended offset; pc is the address of this instruction
  wire logic [PC_W-1:0] off_ext = {
    {(PC_W - CSB_OFFSET_W){issue.offset[CSB_OFFSET_W-1]}}, issue.offset
  };
  wire logic [PC_W-1:0] br_target = issue_pc + off_ext + PC_W'(1);
  wire logic [PC_W-1:0] skip_step = issue.next_two_word
                                    ? PC_W'(CSB_SKIP_TWO_WORD)
                                    : PC_W'(CSB_SKIP_ONE_WORD);
  wire logic [PC_W-1:0] skip_target = issue_pc + skip_step;

  // ----------------------------------------------------------------
  // cycle cost of the issued instruction
  // ----------------------------------------------------------------
  // skip cost by outcome and length
  wire logic [2:0] skip_cyc = ~skip_cond ? CSB_CYC_ONE
                              : issue.next_two_word ? CSB_CYC_THREE
                              : CSB_CYC_TWO;
  // taken branch costs the flushed fetch
  wire logic [2:0] br_cyc = br_cond ? CSB_CYC_TWO : CSB_CYC_ONE;
  wire logic [2:0] cyc = is_ret ? CSB_CYC_RETURN
                         : is_skip ? skip_cyc
                         : is_branch ? br_cyc
                         : CSB_CYC_ONE;

  // results of the issued instruction
  wire logic iss_flags_we = is_cmp | is_ret;
  wire logic [7:0] iss_flags = is_ret ? ret_flags : cmp_flags;
  wire logic iss_pc_load = (is_skip & skip_cond) | (is_branch & br_cond)
                           | is_ret;
  wire logic [PC_W-1:0] iss_pc = is_skip ? skip_target : br_target;
  wire logic one_cyc = cyc == CSB_CYC_ONE;

  // ----------------------------------------------------------------
  // sequencing: one-cycle instructions finish at the next edge,
  // longer ones hold issue_ready low and count down
  // ----------------------------------------------------------------
  wire logic last = (state == CSB_HOLD) & (cnt == 3'h0);
  wire logic fin_now = take & one_cyc;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      CSB_IDLE: begin
        if (take && !one_cyc) begin
          next_state = CSB_HOLD;
          next_cnt = cyc - 3'h2;
        end
      end
      CSB_HOLD: begin
        if (cnt == 3'h0) begin
          next_state = CSB_IDLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      default: begin
        next_state = CSB_IDLE;
        next_cnt = 3'h0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CSB_IDLE;
      cnt <= 3'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // results of a multi-cycle instruction wait here until its last cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ret <= 1'b0;
      pend_flags_we <= 1'b0;
      pend_flags <= 8'h00;
      pend_pc_load <= 1'b0;
      pend_pc <= '0;
    end else if (take) begin
      pend_ret <= is_ret;
      pend_flags_we <= iss_flags_we;
      pend_flags <= iss_flags;
      pend_pc_load <= iss_pc_load;
      pend_pc <= iss_pc;
    end
  end

  // pc from the popped return address
  wire logic [PC_W-1:0] fin_pc = pend_ret ? stack_data : pend_pc;

  // ----------------------------------------------------------------
  // registered outputs; a taken skip or branch also squashes the
  // instruction the fetch stage already holds
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      issue_ready <= 1'b1;
      stack_pop_req <= 1'b0;
      done <= 1'b0;
      flags_we <= 1'b0;
      flags_out <= 8'h00;
      pc_load <= 1'b0;
      pc_value <= '0;
      flush <= 1'b0;
    end else begin
      issue_ready <= fin_now | last | (issue_ready & ~take);
      // pop request one cycle after issue
      stack_pop_req <= take & is_ret;
      done <= fin_now | last;
      flags_we <= fin_now ? iss_flags_we : last & pend_flags_we;
      flags_out <= fin_now ? iss_flags : pend_flags;
      pc_load <= fin_now ? iss_pc_load : last & pend_pc_load;
      pc_value <= fin_now ? iss_pc : fin_pc;
      flush <= fin_now ? iss_pc_load : last & pend_pc_load;
    end
  end

endmodule : csb_unit
